// *** bench/itbw_slave.sv ***
// Purpose: behavioural I2C slave on the open-drain wires
// Assumes: wires have pull-ups; sampled on sys_clk_i
// Notes:   stretches SCL after every falling edge between START and STOP when stretch_i is set
module itbw_slave (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // Bench control
  input  wire logic       nack_i,
  input  wire logic [7:0] stretch_i,
  // Bus wires
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_oe_o,
  output logic            sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  int         stops;
  int         bitc;
  int         hold;
  logic [7:0] sh;
  logic       scl_d;
  logic       sda_d;
  logic       active;
  logic       in_ack;
  always @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      {scl_d, sda_d, active, in_ack, scl_oe_o, sda_oe_o} <= 6'h30;
      {stops, bitc, hold} <= '0;
    end
    else
    begin
      scl_d <= scl_i;
      sda_d <= sda_i;
      if (hold > 1)
        hold <= hold - 1;
      else
        {hold, scl_oe_o} <= '0;
      if (scl_d && scl_i && sda_d && !sda_i)
        {active, in_ack, bitc} <= {2'h2, 32'h0};
      else if (scl_d && scl_i && !sda_d && sda_i)
        {active, stops} <= {1'b0, stops + 1};
      else if (active && !scl_d && scl_i && bitc < 8)
        {sh, bitc} <= {sh[6:0], sda_i, bitc + 1};
      else if (active && scl_d && !scl_i)
      begin
        // Stretch hides the rising edge from the master
        if (stretch_i != 8'h00)
          {scl_oe_o, hold} <= {1'b1, 24'h0, stretch_i};
        if (in_ack)
        begin
          {sda_oe_o, in_ack, bitc} <= '0;
          rx_q.push_back(sh);
        end
        else if (bitc == 8)
          {sda_oe_o, in_ack} <= {~nack_i, 1'b1};
      end
    end
  end
endmodule : itbw_slave

// *** bench/testbench.sv ***
// Purpose: self-checking bench of the ten-bit address write sequencer
// Assumes: short quarter count of 2 gives a 200 ns SCL period, phase 2 taking two quarters
// Notes:   scenarios run in order and share the slave's byte queue
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, rst = 1, en = 0, irq_en = 0, ten = 0;
  logic       start_r = 0, stop_r = 0, wr = 0, nack = 0;
  logic [7:0] data = 8'h00, stretch = 8'h00;
  logic       empty, irq, busy, nack_s, m_scl_oe, m_sda_oe, s_scl_oe, s_sda_oe;
  logic [1:0] bidx;
  wire        scl = ~(m_scl_oe | s_scl_oe);
  wire        sda = ~(m_sda_oe | s_sda_oe);
  int         err_count = 0, tests_run = 0, cyc = 0, cyc_all = 0, s0;
  itbw_master #(.QTR_CYC(2)) itbw_master_i (
    .sys_clk_i(clk), .rst_i(rst), .controller_enable_bit_i(en),
    .transmit_irq_enable_i(irq_en), .ten_bit_i(ten), .start_req_i(start_r),
    .stop_req_i(stop_r), .data_wr_i(wr), .data_i(data),
    .tx_data_empty_flag_o(empty), .irq_o(irq), .busy_o(busy),
    .nack_o(nack_s), .byte_idx_o(bidx), .scl_i(scl), .scl_o(),
    .scl_oe_o(m_scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(m_sda_oe));
  itbw_slave itbw_slave_i (
    .sys_clk_i(clk), .rst_i(rst), .nack_i(nack), .stretch_i(stretch),
    .scl_i(scl), .sda_i(sda), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe));
  initial
  begin
    forever #10 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Ceiling sits far above the thousand or so cycles the scenarios need
  always @(posedge clk)
  begin
    cyc_all++;
    if (cyc_all == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  task wr_byte(input logic [7:0] b);
    @(negedge clk);
    {data, wr} = {b, 1'b1};
    @(negedge clk);
    wr = 0;
  endtask : wr_byte
  task pulse(input bit s);
    @(negedge clk);
    {stop_r, start_r} = {s, ~s};
    @(negedge clk);
    {stop_r, start_r} = 2'h0;
  endtask : pulse
  task wait_empty;
    while (empty !== 1'b1) @(negedge clk);
  endtask : wait_empty
  task wait_idle;
    cyc = 0;
    while (busy !== 1'b0)
    begin
      @(negedge clk);
      cyc++;
    end
    repeat (4) @(negedge clk);
  endtask : wait_idle
  task chk_rx(input logic [7:0] b);
    logic [7:0] g;
    g = 8'hXX;
    if (itbw_slave_i.rx_q.size() > 0)
      g = itbw_slave_i.rx_q.pop_front();
    `CHK(g, b)
  endtask : chk_rx
  //////////////////////////////////////////////////////////////////////
  task t_reset;
    `CHK({empty, irq, busy, nack_s, m_scl_oe, m_sda_oe, bidx}, 8'h80)
  endtask : t_reset
  task t_ten_bit;
    s0 = itbw_slave_i.stops;
    {ten, en} = 2'h3;
    @(negedge clk);
    irq_en = 1;
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wr_byte(8'h06);
    @(negedge clk);
    `CHK({empty, irq}, 2'h0)
    pulse(0);
    wait_empty();
    `CHK(busy, 1'b1)
    wr_byte(8'h5A);
    wait_empty();
    wr_byte(8'hC3);
    wait_empty();
    irq_en = 0;
    wait_idle();
    chk_rx(8'hF6);
    chk_rx(8'h5A);
    chk_rx(8'hC3);
    `CHK(itbw_slave_i.stops, s0 + 1)
    `CHK({m_scl_oe, m_sda_oe}, 2'h0)
    `CHK(bidx, 2'h2)
    `CHK(irq, 1'b0)
  endtask : t_ten_bit
  task t_nack;
    s0 = itbw_slave_i.stops;
    nack = 1;
    wr_byte(8'hF2);
    pulse(0);
    wait_empty();
    wr_byte(8'hF0);
    wait_idle();
    chk_rx(8'hF2);
    `CHK({nack_s, empty}, 2'h2)
    `CHK(bidx, 2'h0)
    `CHK(itbw_slave_i.rx_q.size(), 0)
    `CHK(itbw_slave_i.stops, s0 + 1)
    nack = 0;
  endtask : t_nack
  task t_stretch_stop;
    s0 = itbw_slave_i.stops;
    stretch = 8'd40;
    pulse(0);
    wait_empty();
    wr_byte(8'h11);
    pulse(1);
    wait_idle();
    chk_rx(8'hF0);
    `CHK(cyc >= 360, 1'b1)
    `CHK(itbw_slave_i.rx_q.size(), 0)
    `CHK({itbw_slave_i.stops, nack_s}, {s0 + 1, 1'b0})
    stretch = 8'h00;
  endtask : t_stretch_stop
  task t_disable;
    pulse(0);
    wait_empty();
    repeat (30) @(negedge clk);
    en = 0;
    repeat (4) @(negedge clk);
    `CHK({busy, m_scl_oe, m_sda_oe}, 3'h0)
  endtask : t_disable
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 0;
    t_reset();
    t_ten_bit();
    t_nack();
    t_stretch_stop();
    t_disable();
    end_sim();
  end
endmodule : testbench

// *** inc/itbw_map.svh ***
// Purpose: constants of the ten-bit address I2C write sequencer
// Assumes: 50 MHz system clock
// Notes:   timing counts derive from the times below
// Contract
// - Shift register bits go out on SDA
// - Wait for ACK; NACK ends with Stop
// - Slave holding SCL low pauses the bus
// - Stop when data empty or stop requested
// - First byte prefix 11110 plus two MSBs
// - Second address byte, data, acks, Stop
// - Data phase same as seven-bit addressing
// - Interrupt asserts while data register empty
// - Start request drives START on the bus
// - Finish current byte, then place STOP
`ifndef ITBW_MAP_SVH
`define ITBW_MAP_SVH
`define ITBW_CLK_NS      20
`define ITBW_QTR_NS      2500
`define ITBW_QTR_CYC     ((`ITBW_QTR_NS + `ITBW_CLK_NS - 1) / `ITBW_CLK_NS)
`define ITBW_TEN_PREFIX  5'h1E
`define ITBW_BYTE_MSB    7
`endif

// *** inc/itbw_pkg.sv ***
// Purpose: types of the ten-bit address I2C write sequencer
// Assumes: nothing
// Notes:   state codes written out
package itbw_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_BIT   = 3'h2,
    ST_ACK   = 3'h3,
    ST_STOP  = 3'h4
  } itbw_state_type;

  typedef struct packed
  {
    itbw_state_type st;
    logic [7:0]     qcnt;
    logic [1:0]     ph;
    logic [2:0]     bitn;
    logic [7:0]     shift;
    logic [7:0]     hold;
    logic           empty;
    logic           start_pend;
    logic           stop_pend;
    logic [1:0]     byte_idx;
    logic           nack;
    logic           busy;
    logic           irq;
    logic           scl_oe;
    logic           sda_oe;
    logic           scl_m;
    logic           scl_s;
    logic           sda_m;
    logic           sda_s;
  } itbw_regs_type;
endpackage : itbw_pkg

// *** logic/itbw_master.sv ***
// Purpose: I2C master write sequencer with ten-bit slave addressing
// Assumes: control inputs come from logic on sys_clk_i
// Notes:   SDA and SCL are open drain; _o is always low, _oe pulls low
`include "itbw_map.svh"
module itbw_master #(
  parameter int QTR_CYC = `ITBW_QTR_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // Control bits
  input  wire logic        controller_enable_bit_i,
  input  wire logic        transmit_irq_enable_i,
  input  wire logic        ten_bit_i,
  input  wire logic        start_req_i,
  input  wire logic        stop_req_i,
  // Data register write
  input  wire logic        data_wr_i,
  input  wire logic [7:0]  data_i,
  // Status
  output logic             tx_data_empty_flag_o,
  output logic             irq_o,
  output logic             busy_o,
  output logic             nack_o,
  output logic [1:0]       byte_idx_o,
  // Bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o
);
  import itbw_pkg::*;

  itbw_regs_type s;
  itbw_regs_type next_s;
  logic          tick;
  logic          load;
  logic          adv;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_s = s;
    load   = 1'b0;
    adv    = 1'b0;
    tick   = (s.qcnt == 8'(QTR_CYC - 1));
    next_s.scl_m = scl_i;
    next_s.scl_s = s.scl_m;
    next_s.sda_m = sda_i;
    next_s.sda_s = s.sda_m;
    if (s.st == ST_IDLE || tick)
    begin
      next_s.qcnt = 8'h00;
    end
    else
    begin
      next_s.qcnt = s.qcnt + 8'h01;
    end
    // Phase 2 waits for SCL to read high so a stretching slave pauses us
    if (tick)
    begin
      adv = (s.ph != 2'h2) || s.scl_s;
    end
    case (s.st)
      ST_IDLE:
      begin
        next_s.busy = 1'b0;
        if (s.start_pend && !s.empty)
        begin
          load              = 1'b1;
          next_s.start_pend = 1'b0;
          next_s.nack       = 1'b0;
          next_s.byte_idx   = 2'h0;
          next_s.busy       = 1'b1;
          next_s.ph         = 2'h0;
          next_s.st         = ST_START;
        end
      end
      ST_START:
      begin
        if (adv)
        begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0:    next_s.sda_oe = 1'b0;
            2'h2:    next_s.sda_oe = 1'b1;
            2'h3:
            begin
              next_s.scl_oe = 1'b1;
              next_s.bitn   = 3'(`ITBW_BYTE_MSB);
              next_s.st     = ST_BIT;
            end
            default: next_s.scl_oe = 1'b0;
          endcase
        end
      end
      ST_BIT:
      begin
        if (adv)
        begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0:    next_s.sda_oe = ~s.shift[7];
            2'h1:    next_s.scl_oe = 1'b0;
            2'h3:
            begin
              next_s.scl_oe = 1'b1;
              next_s.shift  = {s.shift[6:0], 1'b0};
              next_s.bitn   = s.bitn - 3'h1;
              if (s.bitn == 3'h0)
              begin
                next_s.st = ST_ACK;
              end
            end
            default: next_s.ph = s.ph + 2'h1;
          endcase
        end
      end
      ST_ACK:
      begin
        if (adv)
        begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0:    next_s.sda_oe = 1'b0;
            2'h1:    next_s.scl_oe = 1'b0;
            2'h3:
            begin
              next_s.scl_oe = 1'b1;
              next_s.nack   = s.sda_s;
              if (s.sda_s || s.empty || s.stop_pend)
              begin
                next_s.st = ST_STOP;
              end
              else
              begin
                // Second address byte then data, handled alike
                load          = 1'b1;
                next_s.bitn   = 3'(`ITBW_BYTE_MSB);
                next_s.st     = ST_BIT;
                if (s.byte_idx != 2'h3)
                begin
                  next_s.byte_idx = s.byte_idx + 2'h1;
                end
              end
            end
            default: next_s.ph = s.ph + 2'h1;
          endcase
        end
      end
      ST_STOP:
      begin
        if (adv)
        begin
          next_s.ph = s.ph + 2'h1;
          case (s.ph)
            2'h0:    next_s.sda_oe = 1'b1;
            2'h1:    next_s.scl_oe = 1'b0;
            2'h3:
            begin
              next_s.sda_oe    = 1'b0;
              next_s.stop_pend = 1'b0;
              next_s.st        = ST_IDLE;
            end
            default: next_s.ph = s.ph + 2'h1;
          endcase
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
    // Requests land after the clears so one arriving with a clear survives
    if (start_req_i)
    begin
      next_s.start_pend = 1'b1;
    end
    if (stop_req_i)
    begin
      next_s.stop_pend = 1'b1;
    end
    if (load)
    begin
      next_s.shift = s.hold;
      if (s.st == ST_IDLE && ten_bit_i)
      begin
        next_s.shift[7:3] = `ITBW_TEN_PREFIX;
      end
      next_s.empty = 1'b1;
    end
    // A write in the load cycle leaves the new byte pending
    if (data_wr_i)
    begin
      next_s.hold  = data_i;
      next_s.empty = 1'b0;
    end
    // Disabling abandons the transfer; the held byte stays
    if (!controller_enable_bit_i)
    begin
      next_s.st         = ST_IDLE;
      next_s.ph         = 2'h0;
      next_s.scl_oe     = 1'b0;
      next_s.sda_oe     = 1'b0;
      next_s.busy       = 1'b0;
      next_s.start_pend = 1'b0;
      next_s.stop_pend  = 1'b0;
    end
    next_s.irq = transmit_irq_enable_i && next_s.empty;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s       <= '0;
      s.empty <= 1'b1;
      s.scl_m <= 1'b1;
      s.scl_s <= 1'b1;
      s.sda_m <= 1'b1;
      s.sda_s <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tx_data_empty_flag_o = s.empty;
  assign irq_o                = s.irq;
  assign busy_o               = s.busy;
  assign nack_o               = s.nack;
  assign byte_idx_o           = s.byte_idx;
  assign scl_o                = 1'b0;
  assign sda_o                = 1'b0;
  assign scl_oe_o             = s.scl_oe;
  assign sda_oe_o             = s.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking chk_clk @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence ack_end;
    s.st == ST_ACK && s.ph == 2'h3 && tick;
  endsequence

  // START only advances once SCL reads high
  sequence start_fall;
    s.st == ST_START && s.ph == 2'h2 && tick && s.scl_s &&
    controller_enable_bit_i;
  endsequence

  a_irq_follows: assert property (
    irq_o == ($past(transmit_irq_enable_i) && s.empty))
    else $error("irq does not follow empty flag");
  a_write_clears: assert property (
    data_wr_i |=> !s.empty && s.hold == $past(data_i))
    else $error("write did not clear empty flag");
  a_load_sets: assert property (
    load && !data_wr_i |=> s.empty)
    else $error("load did not set empty flag");
  a_disable_idle: assert property (
    !controller_enable_bit_i |=> s.st == ST_IDLE && !scl_oe_o && !sda_oe_o)
    else $error("disable did not release the bus");
  a_stretch_hold: assert property (
    s.st == ST_BIT && s.ph == 2'h2 && !s.scl_s && controller_enable_bit_i
    |=> s.st == ST_BIT && s.ph == 2'h2)
    else $error("bit advanced while SCL held low");
  a_nack_stop: assert property (
    ack_end and s.sda_s && controller_enable_bit_i
    |=> s.st == ST_STOP && nack_o)
    else $error("nack not followed by stop");
  a_empty_stop: assert property (
    ack_end and (s.empty || s.stop_pend) && controller_enable_bit_i
    |=> s.st == ST_STOP)
    else $error("no stop on empty or stop request");
  a_prefix_load: assert property (
    load && s.st == ST_IDLE && ten_bit_i && controller_enable_bit_i
    |=> s.shift[7:3] == `ITBW_TEN_PREFIX)
    else $error("ten-bit prefix missing");
  a_start_cond: assert property (
    start_fall |=> sda_oe_o && !scl_oe_o)
    else $error("start condition malformed");
  a_bit_drive: assert property (
    s.st == ST_BIT && s.ph == 2'h1 |-> sda_oe_o == !s.shift[7])
    else $error("SDA not driven from shift msb");
  a_stop_release: assert property (
    s.st == ST_STOP && s.ph == 2'h3 && tick && controller_enable_bit_i
    |=> s.st == ST_IDLE && !sda_oe_o && !scl_oe_o)
    else $error("stop did not release SDA");
endmodule : itbw_master
